//--- src/crf_pkg.sv
/*
 * Shared constants, encodings and carrier types of the CPU register file block.
 * Assumes a single clock domain and an instruction sequencer on the same clock.
 */
`default_nettype none

package crf_pkg;

    localparam int unsigned CRF_NUM_REGS = 8;
    localparam logic [2:0] CRF_SP_IDX = 3'h7;

    localparam int unsigned CRF_BIT_I = 7;
    localparam int unsigned CRF_BIT_UI = 6;
    localparam int unsigned CRF_BIT_H = 5;
    localparam int unsigned CRF_BIT_U = 4;
    localparam int unsigned CRF_BIT_N = 3;
    localparam int unsigned CRF_BIT_Z = 2;
    localparam int unsigned CRF_BIT_V = 1;
    localparam int unsigned CRF_BIT_C = 0;

    localparam int unsigned CRF_HALF_BIT_B = 3;
    localparam int unsigned CRF_HALF_BIT_W = 11;
    localparam int unsigned CRF_HALF_BIT_L = 27;
    localparam int unsigned CRF_MSB_B = 7;
    localparam int unsigned CRF_MSB_W = 15;
    localparam int unsigned CRF_MSB_L = 31;

    localparam logic [31:0] CRF_MASK_B = 32'h0000_00FF;
    localparam logic [31:0] CRF_MASK_W = 32'h0000_FFFF;
    localparam logic [31:0] CRF_MASK_L = 32'hFFFF_FFFF;

    localparam logic [7:0] CRF_FLAGS_RST = 8'h80;
    localparam logic [31:0] CRF_GPR_RST = 32'h0000_0000;
    localparam logic [23:0] CRF_PC_RST = 24'h00_0000;
    localparam logic [23:0] CRF_PC_STEP = 24'h00_0002;
    localparam logic [23:0] CRF_FETCH_MASK = 24'hFF_FFFE;
    localparam logic [23:0] CRF_ADDR20_MASK = 24'h0F_FFFF;

    typedef enum logic [1:0] {
        CRF_SZ_B = 2'b00,
        CRF_SZ_W = 2'b01,
        CRF_SZ_L = 2'b10
    } crf_size_t;

    typedef enum logic [3:0] {
        CRF_OP_ADD = 4'b0000,
        CRF_OP_ADDX = 4'b0001,
        CRF_OP_SUB = 4'b0010,
        CRF_OP_SUBX = 4'b0011,
        CRF_OP_CMP = 4'b0100,
        CRF_OP_NEG = 4'b0101,
        CRF_OP_SHIFT = 4'b0110,
        CRF_OP_LOGIC = 4'b0111
    } crf_alu_op_t;

    typedef enum logic [2:0] {
        CRF_FL_NONE = 3'b000,
        CRF_FL_LOAD = 3'b001,
        CRF_FL_AND = 3'b010,
        CRF_FL_OR = 3'b011,
        CRF_FL_XOR = 3'b100
    } crf_flag_op_t;

    typedef enum logic [2:0] {
        CRF_BIT_NONE = 3'b000,
        CRF_BIT_LD = 3'b001,
        CRF_BIT_AND = 3'b010,
        CRF_BIT_OR = 3'b011,
        CRF_BIT_XOR = 3'b100
    } crf_bit_op_t;

    typedef enum logic [2:0] {
        CRF_SP_HOLD = 3'b000,
        CRF_SP_DEC2 = 3'b001,
        CRF_SP_DEC4 = 3'b010,
        CRF_SP_INC2 = 3'b011,
        CRF_SP_INC4 = 3'b100
    } crf_sp_step_t;

    typedef logic [CRF_NUM_REGS-1:0][31:0] crf_gpr_file_t;

    typedef struct packed {
        crf_size_t size;
        logic [3:0] idx;
    } crf_rsel_t;

    typedef struct packed {
        logic en;
        crf_size_t size;
        logic [3:0] idx;
        logic [31:0] data;
    } crf_wr_t;

    typedef struct packed {
        logic valid;
        crf_alu_op_t op;
        crf_size_t size;
        logic [31:0] a;
        logic [31:0] b;
        logic shift_out;
        logic wr_en;
        logic [3:0] dst;
    } crf_alu_req_t;

    typedef struct packed {
        crf_bit_op_t op;
        logic invert;
        logic bit_in;
    } crf_bit_req_t;

    typedef struct packed {
        crf_flag_op_t op;
        logic [7:0] imm;
    } crf_flag_req_t;

    typedef struct packed {
        logic load;
        logic [23:0] value;
        logic advance;
    } crf_pc_req_t;

    typedef struct packed {
        crf_gpr_file_t gpr;
        logic [7:0] flags;
        logic [23:0] pc;
        logic [23:0] fetch_addr;
        logic [23:0] ea;
        logic [31:0] rd_a;
        logic [31:0] rd_b;
        logic [31:0] alu_res;
        logic irq_ok;
        logic nmi_ok;
        logic taken;
    } crf_state_t;

    localparam crf_state_t CRF_STATE_RST = '{
        gpr: {CRF_NUM_REGS{CRF_GPR_RST}},
        flags: CRF_FLAGS_RST,
        pc: CRF_PC_RST,
        fetch_addr: CRF_PC_RST,
        ea: CRF_PC_RST,
        rd_a: CRF_GPR_RST,
        rd_b: CRF_GPR_RST,
        alu_res: CRF_GPR_RST,
        irq_ok: 1'b0,
        nmi_ok: 1'b0,
        taken: 1'b0
    };

endpackage

`default_nettype wire

//--- src/crf_core.sv
/*
 * Programmer-visible CPU state: eight general registers with 32/16/8-bit views,
 * the stack pointer, the program counter, the condition flags and their update logic.
 * Assumes the sequencer, interrupt controller and address datapath share core_clk
 * and present at most one instruction's worth of requests per cycle.
 */
`default_nettype none

// Behaviour
// - Eight identical 32-bit registers, any access size.
// - Each splits into upper and lower halves.
// - Lower half splits into high and low bytes.
// - Eighth register doubles as stack pointer.
// - 24-bit program counter, fetch forces bit zero.
// - Eight-bit flags register with fixed bit layout.
// - Mask bit blocks all but non-maskable interrupt.
// - Exception handling start sets the mask bit.
// - Bits six and four freely software accessible.
// - Byte arithmetic half-carry taken at bit three.
// - Word arithmetic half-carry taken at bit eleven.
// - Long arithmetic half-carry taken at bit 27.
// - Negative flag copies the result sign.
// - Zero flag marks an all-zero result.
// - Overflow flag marks arithmetic overflow, else cleared.
// - Carry holds carry, borrow or shifted-out bit.
// - Bit instructions use carry as accumulator.
// - Flags loadable, storable, AND/OR/XOR modifiable.
// - Branch conditions come from N, Z, V, C.
// - Reset loads vector, sets mask, nothing else; reset_n here zeroes registers, PC and other flags, vec_load loads the vector.
// - One-megabyte modes drop upper four address bits.
module crf_core
    import crf_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire crf_wr_t gpr_wr,
    input wire crf_rsel_t rd_a_sel,
    input wire crf_rsel_t rd_b_sel,
    input wire crf_alu_req_t alu_req,
    input wire crf_bit_req_t bit_req,
    input wire crf_flag_req_t flag_req,
    input wire crf_sp_step_t sp_step,
    input wire crf_pc_req_t pc_req,
    input wire logic exc_start,
    input wire logic vec_load,
    input wire logic [23:0] vec_addr,
    input wire logic irq_req,
    input wire logic nmi_req,
    input wire logic ui_is_mask,
    input wire logic mode_1m,
    input wire logic [23:0] ea_in,
    input wire logic [3:0] branch_cond,
    output logic [31:0] rd_a_data,
    output logic [31:0] rd_b_data,
    output logic [31:0] alu_result,
    output logic [7:0] condition_flags,
    output logic [31:0] stack_pointer,
    output logic [23:0] program_counter,
    output logic [23:0] fetch_addr,
    output logic [23:0] ea_out,
    output logic irq_accept,
    output logic nmi_accept,
    output logic branch_taken
);

    crf_state_t s_q;
    crf_state_t s_d;

    logic [31:0] mask;
    logic [31:0] op_a;
    logic [31:0] op_b;
    logic [32:0] carry_in;
    logic [32:0] raw;
    logic [32:0] xmix;
    logic [31:0] res;
    logic is_sub;
    logic is_arith;
    logic sign_a;
    logic sign_b;
    logic sign_r;
    logic half_c;
    logic top_c;
    logic bit_val;
    logic [31:0] sp_val;

    // Reads a view of the register file; byte and word views are zero-extended.
    function automatic logic [31:0] crf_get_view(input crf_gpr_file_t f, input crf_rsel_t sel);
        logic [31:0] r;
        r = f[sel.idx[2:0]];
        case (sel.size)
            CRF_SZ_L: crf_get_view = r;
            CRF_SZ_W: crf_get_view = sel.idx[3] ? {16'h0000, r[31:16]} : {16'h0000, r[15:0]};
            CRF_SZ_B: crf_get_view = sel.idx[3] ? {24'h00_0000, r[7:0]} : {24'h00_0000, r[15:8]};
            default: crf_get_view = r;
        endcase
    endfunction

    // Merges new data into one view and keeps every other bit of the register.
    function automatic logic [31:0] crf_put_view(input logic [31:0] old, input crf_size_t size,
                                                 input logic hi, input logic [31:0] data);
        logic [31:0] r;
        r = old;
        case (size)
            CRF_SZ_L: r = data;
            CRF_SZ_W: begin
                if (hi) begin
                    r[31:16] = data[15:0];
                end else begin
                    r[15:0] = data[15:0];
                end
            end
            CRF_SZ_B: begin
                if (hi) begin
                    r[7:0] = data[7:0];
                end else begin
                    r[15:8] = data[7:0];
                end
            end
            default: r = old;
        endcase
        crf_put_view = r;
    endfunction

    // Picks the sign bit of a value for the given operand size.
    function automatic logic crf_sign(input logic [31:0] v, input crf_size_t size);
        case (size)
            CRF_SZ_B: crf_sign = v[CRF_MSB_B];
            CRF_SZ_W: crf_sign = v[CRF_MSB_W];
            default: crf_sign = v[CRF_MSB_L];
        endcase
    endfunction

    // Evaluates a branch condition code against the current flags.
    function automatic logic crf_cond(input logic [3:0] cc, input logic [7:0] f);
        logic n;
        logic z;
        logic v;
        logic c;
        n = f[CRF_BIT_N];
        z = f[CRF_BIT_Z];
        v = f[CRF_BIT_V];
        c = f[CRF_BIT_C];
        case (cc)
            4'h0: crf_cond = 1'b1;
            4'h1: crf_cond = 1'b0;
            4'h2: crf_cond = ~(c | z);
            4'h3: crf_cond = c | z;
            4'h4: crf_cond = ~c;
            4'h5: crf_cond = c;
            4'h6: crf_cond = ~z;
            4'h7: crf_cond = z;
            4'h8: crf_cond = ~v;
            4'h9: crf_cond = v;
            4'hA: crf_cond = ~n;
            4'hB: crf_cond = n;
            4'hC: crf_cond = ~(n ^ v);
            4'hD: crf_cond = n ^ v;
            4'hE: crf_cond = ~(z | (n ^ v));
            default: crf_cond = z | (n ^ v);
        endcase
    endfunction

    always_comb begin
        s_d = s_q;
        mask = CRF_MASK_L;
        op_a = 32'h0000_0000;
        op_b = 32'h0000_0000;
        carry_in = 33'h0_0000_0000;
        raw = 33'h0_0000_0000;
        xmix = 33'h0_0000_0000;
        res = 32'h0000_0000;
        is_sub = 1'b0;
        is_arith = 1'b0;
        half_c = 1'b0;
        top_c = 1'b0;
        bit_val = 1'b0;
        sp_val = 32'h0000_0000;

        // Register write port.
        if (gpr_wr.en) begin
            s_d.gpr[gpr_wr.idx[2:0]] = crf_put_view(s_q.gpr[gpr_wr.idx[2:0]], gpr_wr.size,
                                                    gpr_wr.idx[3], gpr_wr.data);
        end

        // Operand shaping by size.
        case (alu_req.size)
            CRF_SZ_B: mask = CRF_MASK_B;
            CRF_SZ_W: mask = CRF_MASK_W;
            default: mask = CRF_MASK_L;
        endcase
        is_sub = (alu_req.op == CRF_OP_SUB) || (alu_req.op == CRF_OP_SUBX) ||
                 (alu_req.op == CRF_OP_CMP) || (alu_req.op == CRF_OP_NEG);
        is_arith = is_sub || (alu_req.op == CRF_OP_ADD) || (alu_req.op == CRF_OP_ADDX);
        if (alu_req.op == CRF_OP_NEG) begin
            op_a = 32'h0000_0000;
            op_b = alu_req.a & mask;
        end else begin
            op_a = alu_req.a & mask;
            op_b = alu_req.b & mask;
        end
        if ((alu_req.op == CRF_OP_ADDX) || (alu_req.op == CRF_OP_SUBX)) begin
            carry_in = {32'h0000_0000, s_q.flags[CRF_BIT_C]};
        end
        if (is_sub) begin
            raw = {1'b0, op_a} - {1'b0, op_b} - carry_in;
        end else begin
            raw = {1'b0, op_a} + {1'b0, op_b} + carry_in;
        end
        // Each bit of xmix is the carry or borrow that entered that bit position.
        xmix = {1'b0, op_a} ^ {1'b0, op_b} ^ raw;
        case (alu_req.size)
            CRF_SZ_B: begin
                half_c = xmix[CRF_HALF_BIT_B + 1];
                top_c = xmix[CRF_MSB_B + 1];
            end
            CRF_SZ_W: begin
                half_c = xmix[CRF_HALF_BIT_W + 1];
                top_c = xmix[CRF_MSB_W + 1];
            end
            default: begin
                half_c = xmix[CRF_HALF_BIT_L + 1];
                top_c = raw[CRF_MSB_L + 1];
            end
        endcase
        if (is_arith) begin
            res = raw[31:0] & mask;
        end else begin
            res = alu_req.b & mask;
        end
        sign_a = crf_sign(op_a, alu_req.size);
        sign_b = crf_sign(op_b, alu_req.size);
        sign_r = crf_sign(res, alu_req.size);

        // Flag update and result write-back.
        if (alu_req.valid) begin
            s_d.alu_res = res;
            s_d.flags[CRF_BIT_N] = sign_r;
            s_d.flags[CRF_BIT_Z] = (res == 32'h0000_0000);
            if (is_arith) begin
                s_d.flags[CRF_BIT_H] = half_c;
                s_d.flags[CRF_BIT_C] = top_c;
                if (is_sub) begin
                    s_d.flags[CRF_BIT_V] = (sign_a != sign_b) && (sign_r != sign_a);
                end else begin
                    s_d.flags[CRF_BIT_V] = (sign_a == sign_b) && (sign_r != sign_a);
                end
            end else if (alu_req.op == CRF_OP_SHIFT) begin
                s_d.flags[CRF_BIT_V] = 1'b0;
                s_d.flags[CRF_BIT_C] = alu_req.shift_out;
            end else begin
                s_d.flags[CRF_BIT_V] = 1'b0;
            end
            if (alu_req.wr_en && (alu_req.op != CRF_OP_CMP)) begin
                s_d.gpr[alu_req.dst[2:0]] = crf_put_view(s_d.gpr[alu_req.dst[2:0]], alu_req.size,
                                                         alu_req.dst[3], res);
            end
        end

        // Carry as one-bit accumulator.
        bit_val = bit_req.bit_in ^ bit_req.invert;
        case (bit_req.op)
            CRF_BIT_LD: s_d.flags[CRF_BIT_C] = bit_val;
            CRF_BIT_AND: s_d.flags[CRF_BIT_C] = s_q.flags[CRF_BIT_C] & bit_val;
            CRF_BIT_OR: s_d.flags[CRF_BIT_C] = s_q.flags[CRF_BIT_C] | bit_val;
            CRF_BIT_XOR: s_d.flags[CRF_BIT_C] = s_q.flags[CRF_BIT_C] ^ bit_val;
            default: s_d.flags[CRF_BIT_C] = s_d.flags[CRF_BIT_C];
        endcase

        // Whole-register flag instructions reach every bit, bits six and four included.
        case (flag_req.op)
            CRF_FL_LOAD: s_d.flags = flag_req.imm;
            CRF_FL_AND: s_d.flags = s_q.flags & flag_req.imm;
            CRF_FL_OR: s_d.flags = s_q.flags | flag_req.imm;
            CRF_FL_XOR: s_d.flags = s_q.flags ^ flag_req.imm;
            default: s_d.flags = s_d.flags;
        endcase

        // Implicit stack pointer adjustment after any explicit write.
        sp_val = s_d.gpr[CRF_SP_IDX];
        case (sp_step)
            CRF_SP_DEC2: s_d.gpr[CRF_SP_IDX] = sp_val - 32'h0000_0002;
            CRF_SP_DEC4: s_d.gpr[CRF_SP_IDX] = sp_val - 32'h0000_0004;
            CRF_SP_INC2: s_d.gpr[CRF_SP_IDX] = sp_val + 32'h0000_0002;
            CRF_SP_INC4: s_d.gpr[CRF_SP_IDX] = sp_val + 32'h0000_0004;
            default: s_d.gpr[CRF_SP_IDX] = sp_val;
        endcase

        // Program counter; the reset vector overrides any other load.
        if (vec_load) begin
            s_d.pc = vec_addr;
        end else if (pc_req.load) begin
            s_d.pc = pc_req.value;
        end else if (pc_req.advance) begin
            s_d.pc = (s_q.pc & CRF_FETCH_MASK) + CRF_PC_STEP;
        end

        // Exception entry sets the mask last, so it wins over a flag instruction.
        if (exc_start || vec_load) begin
            s_d.flags[CRF_BIT_I] = 1'b1;
        end

        // Fetch and effective addresses, truncated in one-megabyte modes.
        s_d.fetch_addr = s_d.pc & CRF_FETCH_MASK;
        s_d.ea = ea_in;
        if (mode_1m) begin
            s_d.fetch_addr = s_d.fetch_addr & CRF_ADDR20_MASK;
            s_d.ea = ea_in & CRF_ADDR20_MASK;
        end

        // Read ports show the registers as they stood before this edge.
        s_d.rd_a = crf_get_view(s_q.gpr, rd_a_sel);
        s_d.rd_b = crf_get_view(s_q.gpr, rd_b_sel);

        // Interrupt acceptance from the current mask bits.
        s_d.irq_ok = irq_req && !s_q.flags[CRF_BIT_I] &&
                     !(ui_is_mask && s_q.flags[CRF_BIT_UI]);
        s_d.nmi_ok = nmi_req;

        s_d.taken = crf_cond(branch_cond, s_q.flags);
    end

    // The whole state resets to constants; register contents after reset carry no meaning.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= CRF_STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_a_data = s_q.rd_a;
    assign rd_b_data = s_q.rd_b;
    assign alu_result = s_q.alu_res;
    assign condition_flags = s_q.flags;
    assign stack_pointer = s_q.gpr[CRF_SP_IDX];
    assign program_counter = s_q.pc;
    assign fetch_addr = s_q.fetch_addr;
    assign ea_out = s_q.ea;
    assign irq_accept = s_q.irq_ok;
    assign nmi_accept = s_q.nmi_ok;
    assign branch_taken = s_q.taken;

endmodule

`default_nettype wire

//--- test/crf_core_checker.sv
/*
 * Concurrent checks on the ports of the CPU register file core.
 * Assumes the single clock core_clk and the asynchronous active-low reset_n.
 */
`default_nettype none

module crf_core_checker
    import crf_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire crf_alu_req_t alu_req,
    input wire crf_bit_req_t bit_req,
    input wire crf_flag_req_t flag_req,
    input wire logic exc_start,
    input wire logic vec_load,
    input wire logic [23:0] vec_addr,
    input wire logic irq_req,
    input wire logic nmi_req,
    input wire logic ui_is_mask,
    input wire logic mode_1m,
    input wire logic [23:0] ea_in,
    input wire logic [31:0] alu_result,
    input wire logic [7:0] condition_flags,
    input wire logic [23:0] program_counter,
    input wire logic [23:0] fetch_addr,
    input wire logic [23:0] ea_out,
    input wire logic irq_accept,
    input wire logic nmi_accept
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [28:0] half_sum;
    logic half_c;
    logic quiet;
    logic irq_ok;
    assign half_sum = {1'b0, alu_req.a[27:0]} + {1'b0, alu_req.b[27:0]};
    assign half_c = half_sum[28];
    assign quiet = flag_req.op == CRF_FL_NONE && bit_req.op == CRF_BIT_NONE && !exc_start && !vec_load;
    assign irq_ok = irq_req && !condition_flags[7] && !(ui_is_mask && condition_flags[6]);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    property p_fetch;
        fetch_addr == (program_counter & CRF_FETCH_MASK & ($past(mode_1m) ? CRF_ADDR20_MASK : 24'hFF_FFFF));
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch address mismatch");
    property p_ea;
        ea_out == ($past(ea_in) & ($past(mode_1m) ? CRF_ADDR20_MASK : 24'hFF_FFFF));
    endproperty
    a_ea: assert property (p_ea) else $error("effective address mismatch");
    property p_nmi;
        nmi_accept == $past(nmi_req);
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi accept mismatch");
    property p_irq;
        irq_accept == $past(irq_ok);
    endproperty
    a_irq: assert property (p_irq) else $error("irq accept mismatch");
    property p_exc;
        (exc_start || vec_load) |=> condition_flags[7];
    endproperty
    a_exc: assert property (p_exc) else $error("mask bit not set");
    property p_vec;
        vec_load |=> program_counter == $past(vec_addr);
    endproperty
    a_vec: assert property (p_vec) else $error("vector not loaded");
    property p_hold;
        !alu_req.valid && quiet |=> $stable(condition_flags) && $stable(alu_result);
    endproperty
    a_hold: assert property (p_hold) else $error("flags changed while idle");
    property p_add;
        alu_req.valid && alu_req.op == CRF_OP_ADD && alu_req.size == CRF_SZ_L && quiet
            |=> condition_flags[5] == $past(half_c) && condition_flags[3] == alu_result[31]
                && condition_flags[2] == (alu_result == 32'h0000_0000);
    endproperty
    a_add: assert property (p_add) else $error("long add flags wrong");
endmodule

bind crf_core crf_core_checker u_crf_chk (.*);

`default_nettype wire

//--- test/test_cpu_register_file_and_flags.sv
/*
 * Random self-checking bench for the CPU register file core with fixed corner cases.
 * Assumes crf_pkg, crf_core and the bound checker are compiled before it.
 */
`default_nettype none

module test_cpu_register_file_and_flags
    import crf_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    crf_wr_t gpr_wr;
    crf_rsel_t rd_a_sel;
    crf_rsel_t rd_b_sel;
    crf_alu_req_t alu_req;
    crf_bit_req_t bit_req;
    crf_flag_req_t flag_req;
    crf_sp_step_t sp_step;
    crf_pc_req_t pc_req;
    logic exc_start, vec_load, irq_req, nmi_req, ui_is_mask, mode_1m;
    logic [23:0] vec_addr, ea_in, program_counter, fetch_addr, ea_out, m_pc;
    logic [3:0] branch_cond;
    logic [31:0] rd_a_data, rd_b_data, alu_result, stack_pointer, m_res, e_rda, e_rdb;
    logic [7:0] condition_flags, m_fl;
    logic irq_accept, nmi_accept, branch_taken, e_br;
    logic [31:0] m_reg [8];
    logic [15:0] lfsr_q = 16'hCC8E;
    int num_errors = 0;
    int n_tests = 0;

    crf_core dut (.*);

    always #12.5 core_clk = ~core_clk;

    function automatic logic [15:0] rnd();
        lfsr_q = {1'b0, lfsr_q[15:1]} ^ (lfsr_q[0] ? 16'hB400 : 16'h0000);
        return lfsr_q;
    endfunction

    function automatic logic [31:0] rd_view(crf_rsel_t s);
        logic [31:0] r;
        r = m_reg[s.idx[2:0]];
        case (s.size)
            CRF_SZ_W: return s.idx[3] ? {16'h0000, r[31:16]} : {16'h0000, r[15:0]};
            CRF_SZ_B: return s.idx[3] ? {24'h00_0000, r[7:0]} : {24'h00_0000, r[15:8]};
            default: return r;
        endcase
    endfunction

    task automatic wr_view(crf_size_t sz, logic [3:0] x, logic [31:0] d);
        case (sz)
            CRF_SZ_L: m_reg[x[2:0]] = d;
            CRF_SZ_W: if (x[3]) m_reg[x[2:0]][31:16] = d[15:0]; else m_reg[x[2:0]][15:0] = d[15:0];
            CRF_SZ_B: if (x[3]) m_reg[x[2:0]][7:0] = d[7:0]; else m_reg[x[2:0]][15:8] = d[7:0];
            default: ;
        endcase
    endtask

    function automatic logic taken(logic [3:0] c, logic [7:0] f);
        logic r;
        case (c[3:1])
            3'h0: r = 1'b1;
            3'h1: r = !(f[0] || f[2]);
            3'h2: r = !f[0];
            3'h3: r = !f[2];
            3'h4: r = !f[1];
            3'h5: r = !f[3];
            3'h6: r = f[3] == f[1];
            default: r = !f[2] && f[3] == f[1];
        endcase
        return c[0] ? !r : r;
    endfunction

    task automatic alu_model();
        logic [32:0] m, hm, a, b, r;
        int w, h;
        logic ci;
        w = alu_req.size == CRF_SZ_B ? 8 : alu_req.size == CRF_SZ_W ? 16 : 32;
        h = w == 8 ? 3 : w == 16 ? 11 : 27;
        m = (33'h1 << w) - 33'h1;
        hm = (33'h1 << (h + 1)) - 33'h1;
        a = {1'b0, alu_req.a} & m;
        b = {1'b0, alu_req.b} & m;
        ci = alu_req.op inside {CRF_OP_ADDX, CRF_OP_SUBX} ? m_fl[0] : 1'b0;
        if (alu_req.op == CRF_OP_NEG) begin
            b = a;
            a = 33'h0;
        end
        if (alu_req.op >= CRF_OP_SHIFT) begin
            r = b;
            if (alu_req.op == CRF_OP_SHIFT) m_fl[0] = alu_req.shift_out;
            m_fl[1] = 1'b0;
        end else if (alu_req.op inside {CRF_OP_SUB, CRF_OP_SUBX, CRF_OP_CMP, CRF_OP_NEG}) begin
            r = (a - b - ci) & m;
            m_fl[0] = a < b + ci;
            m_fl[5] = (a & hm) < (b & hm) + ci;
            m_fl[1] = a[w-1] != b[w-1] && r[w-1] != a[w-1];
        end else begin
            r = a + b + ci;
            m_fl[0] = r[w];
            m_fl[5] = (((a & hm) + (b & hm) + ci) >> (h + 1)) != 33'h0;
            r = r & m;
            m_fl[1] = a[w-1] == b[w-1] && r[w-1] != a[w-1];
        end
        m_fl[3] = r[w-1];
        m_fl[2] = r == 33'h0;
        m_res = r[31:0];
        if (alu_req.wr_en && alu_req.op != CRF_OP_CMP) wr_view(alu_req.size, alu_req.dst, r[31:0]);
    endtask

    task automatic drive(int i);
        logic [15:0] c, k, g;
        logic v;
        logic [7:0] f0;
        f0 = m_fl;
        c = rnd();
        k = rnd();
        g = rnd();
        gpr_wr = '{c[0], crf_size_t'(c[2:1]), c[6:3], {rnd(), rnd()}};
        rd_a_sel = '{crf_size_t'(c[8:7]), c[12:9]};
        rd_b_sel = '{crf_size_t'(k[1:0]), k[5:2]};
        alu_req = '{c[15], crf_alu_op_t'(k[8:6]), crf_size_t'(k[10:9] % 3), {rnd(), rnd()},
            {rnd(), rnd()}, k[11], k[12], {c[13], k[15:13]}};
        if (k[5]) alu_req.b = alu_req.a;
        if (alu_req.op inside {CRF_OP_ADDX, CRF_OP_SUBX}) alu_req.size = CRF_SZ_B;
        bit_req = '{c[15:14] == 2'b01 && k[2:0] < 5 ? crf_bit_op_t'(k[2:0]) : CRF_BIT_NONE, g[13], g[14]};
        flag_req = '{c[15:14] == 2'b00 && k[2:0] < 5 ? crf_flag_op_t'(k[2:0]) : CRF_FL_NONE, k[15:8]};
        sp_step = g[2:0] < 5 ? crf_sp_step_t'(g[2:0]) : CRF_SP_HOLD;
        pc_req = '{g[0] & g[1], {g[15:8], rnd()}, g[2]};
        exc_start = &g[5:3];
        vec_load = &g[8:6];
        vec_addr = {g[7:0], rnd()};
        {irq_req, nmi_req, ui_is_mask, mode_1m, branch_cond} = {g[12:9], k[15:12]};
        ea_in = {k[7:0], rnd()};
        if (i == 0) begin
            vec_load = 1'b1;
            vec_addr = 24'h12_3457;
        end
        if (i == 1) gpr_wr = '{1'b1, CRF_SZ_L, 4'h7, 32'h0000_2000};
        if (i inside {[2:4]}) begin
            alu_req = '{1'b1, CRF_OP_ADD, crf_size_t'(i - 2),
                i == 2 ? 32'h0000_000F : i == 3 ? 32'h0000_0FFF : 32'h0FFF_FFFF, 32'h0000_0001, 1'b0, 1'b1, 4'h0};
            bit_req.op = CRF_BIT_NONE;
            flag_req.op = CRF_FL_NONE;
        end
        e_rda = rd_view(rd_a_sel);
        e_rdb = rd_view(rd_b_sel);
        e_br = taken(branch_cond, m_fl);
        if (gpr_wr.en) wr_view(gpr_wr.size, gpr_wr.idx, gpr_wr.data);
        if (alu_req.valid) alu_model();
        v = bit_req.bit_in ^ bit_req.invert;
        case (bit_req.op)
            CRF_BIT_LD: m_fl[0] = v;
            CRF_BIT_AND: m_fl[0] = f0[0] & v;
            CRF_BIT_OR: m_fl[0] = f0[0] | v;
            CRF_BIT_XOR: m_fl[0] = f0[0] ^ v;
            default: ;
        endcase
        case (flag_req.op)
            CRF_FL_LOAD: m_fl = flag_req.imm;
            CRF_FL_AND: m_fl = f0 & flag_req.imm;
            CRF_FL_OR: m_fl = f0 | flag_req.imm;
            CRF_FL_XOR: m_fl = f0 ^ flag_req.imm;
            default: ;
        endcase
        case (sp_step)
            CRF_SP_DEC2: m_reg[7] -= 32'h0000_0002;
            CRF_SP_DEC4: m_reg[7] -= 32'h0000_0004;
            CRF_SP_INC2: m_reg[7] += 32'h0000_0002;
            CRF_SP_INC4: m_reg[7] += 32'h0000_0004;
            default: ;
        endcase
        if (exc_start || vec_load) m_fl[7] = 1'b1;
        if (vec_load) m_pc = vec_addr;
        else if (pc_req.load) m_pc = pc_req.value;
        else if (pc_req.advance) m_pc = (m_pc & CRF_FETCH_MASK) + CRF_PC_STEP;
    endtask

    task automatic check(logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic compare();
        check(32'(condition_flags), 32'(m_fl));
        check(stack_pointer, m_reg[7]);
        check(32'(program_counter), 32'(m_pc));
        check(rd_a_data, e_rda);
        check(rd_b_data, e_rdb);
        check(alu_result, m_res);
        check(32'(branch_taken), 32'(e_br));
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        {gpr_wr, rd_a_sel, rd_b_sel, alu_req, bit_req, flag_req, pc_req} = '0;
        sp_step = CRF_SP_HOLD;
        {exc_start, vec_load, vec_addr, irq_req, nmi_req, ui_is_mask, mode_1m, ea_in, branch_cond} = '0;
        m_reg = '{default: 32'h0000_0000};
        m_fl = 8'h80;
        m_pc = 24'h00_0000;
        m_res = 32'h0000_0000;
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        check(32'(condition_flags[7]), 32'h0000_0001);
        reset_n = 1'b1;
        for (int i = 0; i < 3000; i++) begin
            @(negedge core_clk);
            if (i > 0) compare();
            drive(i);
        end
        @(negedge core_clk);
        compare();
        final_report();
    end

    initial begin
        #150us;
        num_errors++;
        final_report();
    end
endmodule

`default_nettype wire
